/* File: logic/dfc_pkg.sv */
// register map, field layout, reset values and timing of the
// buffer depth and datapath configuration group
// assumes byte-wide registers on an 8-bit address from the serial port logic
package dfc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SAMPLE_W = 16;

  typedef logic [ADDR_W-1:0] dfc_addr_t;
  typedef logic [DATA_W-1:0] dfc_byte_t;

  // register offsets
  localparam dfc_addr_t OFS_DEPTH_REQUEST = 8'h23;
  localparam dfc_addr_t OFS_DEPTH_READBACK = 8'h24;
  localparam dfc_addr_t OFS_RESET_CONTROL = 8'h25;
  localparam dfc_addr_t OFS_FORMAT_SELECT = 8'h26;
  localparam dfc_addr_t OFS_STAGE_ENABLE = 8'h27;
  localparam dfc_addr_t OFS_UPSAMPLE_SELECT = 8'h28;
  localparam dfc_addr_t OFS_LANE_POWER_DOWN = 8'h39;
  localparam dfc_addr_t OFS_DC_OFFSET_LOW = 8'h3b;

  // field positions
  localparam int unsigned DEPTH_INT_LSB = 4;
  localparam int unsigned DEPTH_INT_MSB = 6;
  localparam int unsigned DEPTH_FRAC_LSB = 0;
  localparam int unsigned DEPTH_FRAC_MSB = 2;
  localparam int unsigned DEPTH_FIELD_W = 3;
  localparam int unsigned RST_REQ_BIT = 0;
  localparam int unsigned RST_ACK_BIT = 1;
  localparam int unsigned FMT_ENCODING_BIT = 7;
  localparam int unsigned FMT_WIDTH_BIT = 0;
  localparam int unsigned SINC_COMP_EN_BIT = 7;
  localparam int unsigned GAIN_OFFSET_EN_BIT = 5;
  localparam int unsigned UPSAMPLE_BIT = 7;
  localparam int unsigned LANE_COUNT = 4;

  // writable bit masks; all other bits read zero except the reset acknowledge bit and the measured depth fields of the depth readback register
  localparam dfc_byte_t MASK_DEPTH_REQUEST = 8'h77;
  localparam dfc_byte_t MASK_RESET_CONTROL = 8'h01;
  localparam dfc_byte_t MASK_FORMAT_SELECT = 8'h81;
  localparam dfc_byte_t MASK_STAGE_ENABLE = 8'ha0;
  localparam dfc_byte_t MASK_UPSAMPLE_SELECT = 8'h80;
  localparam dfc_byte_t MASK_LANE_POWER_DOWN = 8'h0f;
  localparam dfc_byte_t MASK_DC_OFFSET_LOW = 8'hff;

  // reset values
  localparam dfc_byte_t RST_DEPTH_REQUEST = 8'h40;
  localparam dfc_byte_t RST_ZERO = 8'h00;
  localparam logic [DEPTH_FIELD_W-1:0] RST_DEPTH_FIELD = 3'h0;

  // length of the buffer reset pulse, in clock cycles
  localparam logic [3:0] BUF_RESET_CYCLES = 4'h4;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RESETTING,
    SEQ_WAIT_LEVEL,
    SEQ_ACKED
  } dfc_seq_e;

endpackage : dfc_pkg

/* File: logic/dfc_buffer_reset_seq.sv */
// serial-port initiated elastic buffer reset sequencer with acknowledge
// assumes the buffer drops its level_valid during reset and raises it
// once the pointers have settled at the requested distance
`timescale 1ns/100ps
module dfc_buffer_reset_seq (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                reset_req_i,
  input  wire logic                level_valid_i,
  output logic                     buffer_reset_o,
  output logic                     reset_ack_o
);
  import dfc_pkg::*;

  dfc_seq_e   state_q;
  logic       req_q;
  logic [3:0] count_q;

  ////////////////////////////////////////////////////////////////////////
  // request edge: a level left high does not retrigger the buffer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q <= 1'b0;
    end else begin
      req_q <= reset_req_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence: pulse, wait for settled level, acknowledge, wait for clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q        <= SEQ_IDLE;
      count_q        <= 4'h0;
      buffer_reset_o <= 1'b0;
      reset_ack_o    <= 1'b0;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          reset_ack_o <= 1'b0;
          if (reset_req_i && !req_q) begin
            state_q        <= SEQ_RESETTING;
            buffer_reset_o <= 1'b1;
            count_q        <= BUF_RESET_CYCLES - 4'h1;
          end
        end
        SEQ_RESETTING: begin
          if (count_q == 4'h0) begin
            buffer_reset_o <= 1'b0;
            state_q        <= SEQ_WAIT_LEVEL;
          end else begin
            count_q <= count_q - 4'h1;
          end
        end
        SEQ_WAIT_LEVEL: begin
          // ack only once the buffer is running again
          if (level_valid_i) begin
            reset_ack_o <= 1'b1;
            state_q     <= SEQ_ACKED;
          end
        end
        SEQ_ACKED: begin
          if (!reset_req_i) begin
            reset_ack_o <= 1'b0;
            state_q     <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

endmodule : dfc_buffer_reset_seq

/* File: logic/dfc_config_regs.sv */
// buffer depth, buffer reset and input datapath configuration registers
// assumes a byte register port from the serial control port logic,
// one access per strobe, all on clk_i
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module dfc_config_regs (
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  // register port from the serial control port
  input  wire dfc_pkg::dfc_addr_t              reg_addr_i,
  input  wire dfc_pkg::dfc_byte_t              reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output dfc_pkg::dfc_byte_t                   reg_rdata_o,
  // elastic buffer
  input  wire logic [2:0]                      meas_depth_int_i,
  input  wire logic [2:0]                      meas_depth_frac_i,
  input  wire logic                            level_valid_i,
  output logic                                 buffer_reset_o,
  output logic [2:0]                           depth_req_int_o,
  output logic [2:0]                           depth_req_frac_o,
  // datapath controls
  output logic                                 offset_binary_o,
  output logic                                 byte_mode_o,
  output logic                                 sinc_comp_en_o,
  output logic                                 gain_offset_en_o,
  output logic                                 upsample_1x_o,
  output logic [3:0]                           lane_power_off_o,
  // dc offset stage
  input  wire dfc_pkg::dfc_byte_t              dc_offset_high_i,
  input  wire logic [15:0]                     sample_i,
  output logic [15:0]                          sample_o
);
  import dfc_pkg::*;

  logic       rst_meta_q;
  logic       rst_sync_q;
  dfc_byte_t  depth_req_q;
  logic [2:0] depth_rb_int_q;
  logic [2:0] depth_rb_frac_q;
  logic       reset_req_q;
  logic       reset_ack;
  logic       buffer_reset;
  dfc_byte_t  format_q;
  dfc_byte_t  stage_en_q;
  dfc_byte_t  upsample_q;
  dfc_byte_t  lane_pd_q;
  dfc_byte_t  dc_offset_low_q;
  dfc_byte_t  rdata_q;
  logic [15:0] sample_q;

  // masked write: undefined bits never store
  function automatic dfc_byte_t masked(input dfc_byte_t data, input dfc_byte_t mask);
    masked = data & mask;
  endfunction : masked

  function automatic logic hit(input dfc_addr_t ofs);
    hit = reg_wr_i && (reg_addr_i == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer depth request; the range check against the upsample factor
  // is left to software, the buffer clamps nothing here
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      depth_req_q <= RST_DEPTH_REQUEST;
    end else if (hit(OFS_DEPTH_REQUEST)) begin
      depth_req_q <= masked(reg_wdata_i, MASK_DEPTH_REQUEST);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measured depth: captured whenever the buffer reports a settled level;
  // accuracy against the request is the buffer's own property
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      depth_rb_int_q  <= RST_DEPTH_FIELD;
      depth_rb_frac_q <= RST_DEPTH_FIELD;
    end else if (level_valid_i) begin
      depth_rb_int_q  <= meas_depth_int_i;
      depth_rb_frac_q <= meas_depth_frac_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer reset request bit; the acknowledge comes from the sequencer
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reset_req_q <= 1'b0;
    end else if (hit(OFS_RESET_CONTROL)) begin
      reset_req_q <= reg_wdata_i[RST_REQ_BIT];
    end
  end

  dfc_buffer_reset_seq u_reset_seq (
    .clk_i          (clk_i),
    .rst_n_i        (rst_sync_q),
    .reset_req_i    (reset_req_q),
    .level_valid_i  (level_valid_i),
    .buffer_reset_o (buffer_reset),
    .reset_ack_o    (reset_ack)
  );

  ////////////////////////////////////////////////////////////////////////
  // datapath configuration registers
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      format_q        <= RST_ZERO;
      stage_en_q      <= RST_ZERO;
      upsample_q      <= RST_ZERO;
      lane_pd_q       <= RST_ZERO;
      dc_offset_low_q <= RST_ZERO;
    end else begin
      if (hit(OFS_FORMAT_SELECT)) begin
        format_q <= masked(reg_wdata_i, MASK_FORMAT_SELECT);
      end
      if (hit(OFS_STAGE_ENABLE)) begin
        stage_en_q <= masked(reg_wdata_i, MASK_STAGE_ENABLE);
      end
      if (hit(OFS_UPSAMPLE_SELECT)) begin
        upsample_q <= masked(reg_wdata_i, MASK_UPSAMPLE_SELECT);
      end
      if (hit(OFS_LANE_POWER_DOWN)) begin
        lane_pd_q <= masked(reg_wdata_i, MASK_LANE_POWER_DOWN);
      end
      if (hit(OFS_DC_OFFSET_LOW)) begin
        dc_offset_low_q <= masked(reg_wdata_i, MASK_DC_OFFSET_LOW);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= RST_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_DEPTH_REQUEST:   rdata_q <= depth_req_q;
        OFS_DEPTH_READBACK:  rdata_q <= {1'b0, depth_rb_int_q, 1'b0, depth_rb_frac_q};
        OFS_RESET_CONTROL:   rdata_q <= {6'h00, reset_ack, reset_req_q};
        OFS_FORMAT_SELECT:   rdata_q <= format_q;
        OFS_STAGE_ENABLE:    rdata_q <= stage_en_q;
        OFS_UPSAMPLE_SELECT: rdata_q <= upsample_q;
        OFS_LANE_POWER_DOWN: rdata_q <= lane_pd_q;
        OFS_DC_OFFSET_LOW:   rdata_q <= dc_offset_low_q;
        default:             rdata_q <= RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dc offset addition; wraps modulo 2^16, no saturation is applied
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sample_q <= 16'h0000;
    end else if (stage_en_q[GAIN_OFFSET_EN_BIT]) begin
      sample_q <= 16'(sample_i + {dc_offset_high_i, dc_offset_low_q});
    end else begin
      sample_q <= sample_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the flops
  assign reg_rdata_o      = rdata_q;
  assign buffer_reset_o   = buffer_reset;
  assign depth_req_int_o  = depth_req_q[DEPTH_INT_MSB:DEPTH_INT_LSB];
  assign depth_req_frac_o = depth_req_q[DEPTH_FRAC_MSB:DEPTH_FRAC_LSB];
  assign offset_binary_o  = format_q[FMT_ENCODING_BIT];
  assign byte_mode_o      = format_q[FMT_WIDTH_BIT];
  assign sinc_comp_en_o   = stage_en_q[SINC_COMP_EN_BIT];
  assign gain_offset_en_o = stage_en_q[GAIN_OFFSET_EN_BIT];
  assign upsample_1x_o    = upsample_q[UPSAMPLE_BIT];
  assign lane_power_off_o = lane_pd_q[LANE_COUNT-1:0];
  assign sample_o         = sample_q;

endmodule : dfc_config_regs

/* File: test/dfc_config_regs_sva.sv */
// concurrent checks on the configuration register group ports
// assumes it is bound onto dfc_config_regs, one clock domain
`timescale 1ns/100ps
module dfc_config_regs_sva
  import dfc_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               reset_n_i,
  input wire dfc_pkg::dfc_addr_t reg_addr_i,
  input wire dfc_pkg::dfc_byte_t reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire dfc_pkg::dfc_byte_t reg_rdata_o,
  input wire logic               buffer_reset_o,
  input wire logic [2:0]         depth_req_int_o,
  input wire logic [2:0]         depth_req_frac_o,
  input wire logic               offset_binary_o,
  input wire logic               byte_mode_o,
  input wire logic               sinc_comp_en_o,
  input wire logic               gain_offset_en_o,
  input wire logic               upsample_1x_o,
  input wire logic [3:0]         lane_power_off_o,
  input wire logic [15:0]        sample_i,
  input wire logic [15:0]        sample_o
);
  // edges since release; the sample pipe is frozen until the reset copy lifts
  logic [2:0] up_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) up_q <= 3'h0;
    else up_q <= {up_q[1:0], 1'b1};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_wr(a); reg_wr_i && reg_addr_i == a; endsequence
  sequence s_pulse; buffer_reset_o [*4] ##1 !buffer_reset_o; endsequence
  property p_pulse; $rose(buffer_reset_o) |-> s_pulse; endproperty
  property p_depth; s_wr(8'h23) |=> depth_req_int_o == $past(reg_wdata_i[6:4])
    && depth_req_frac_o == $past(reg_wdata_i[2:0]); endproperty
  property p_fmt; s_wr(8'h26) |=> offset_binary_o == $past(reg_wdata_i[7])
    && byte_mode_o == $past(reg_wdata_i[0]); endproperty
  property p_stage; s_wr(8'h27) |=> sinc_comp_en_o == $past(reg_wdata_i[7])
    && gain_offset_en_o == $past(reg_wdata_i[5]); endproperty
  property p_ups; s_wr(8'h28) |=> upsample_1x_o == $past(reg_wdata_i[7]); endproperty
  property p_lane; s_wr(8'h39) |=> lane_power_off_o == $past(reg_wdata_i[3:0]); endproperty
  property p_rd_depth; reg_rd_i && reg_addr_i == 8'h23
    |=> reg_rdata_o == {1'b0, $past(depth_req_int_o), 1'b0, $past(depth_req_frac_o)}; endproperty
  property p_unmapped; reg_rd_i && !(reg_addr_i inside {8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h39, 8'h3b})
    |=> reg_rdata_o == 8'h00; endproperty
  property p_pass; up_q[2] && !gain_offset_en_o |=> sample_o == $past(sample_i); endproperty
  a_pulse: assert property (p_pulse) else $error("buffer reset pulse length wrong");
  a_depth: assert property (p_depth) else $error("depth request outputs wrong");
  a_fmt: assert property (p_fmt) else $error("format outputs wrong");
  a_stage: assert property (p_stage) else $error("stage enables wrong");
  a_ups: assert property (p_ups) else $error("upsample select wrong");
  a_lane: assert property (p_lane) else $error("lane power-down wrong");
  a_rd_depth: assert property (p_rd_depth) else $error("depth request read wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_pass: assert property (p_pass) else $error("sample altered with offset off");
endmodule : dfc_config_regs_sva

bind dfc_config_regs dfc_config_regs_sva i_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .buffer_reset_o(buffer_reset_o), .depth_req_int_o(depth_req_int_o), .depth_req_frac_o(depth_req_frac_o),
  .offset_binary_o(offset_binary_o), .byte_mode_o(byte_mode_o), .sinc_comp_en_o(sinc_comp_en_o),
  .gain_offset_en_o(gain_offset_en_o), .upsample_1x_o(upsample_1x_o), .lane_power_off_o(lane_power_off_o),
  .sample_i(sample_i), .sample_o(sample_o));

/* File: test/tb_dfc_config_regs.sv */
// self-checking bench for the configuration register group
// assumes the checker is bound in; inputs move 1 ns after each rising edge
`timescale 1ns/100ps
module tb_dfc_config_regs;
  import dfc_pkg::*;
  logic      clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, level_valid_i = 1'b0;
  dfc_addr_t reg_addr_i = 8'h00;
  dfc_byte_t reg_wdata_i = 8'h00, dc_offset_high_i = 8'h00, reg_rdata_o;
  logic [2:0] meas_depth_int_i = 3'h0, meas_depth_frac_i = 3'h0, depth_req_int_o, depth_req_frac_o;
  logic [15:0] sample_i = 16'h0000, sample_o, expv;
  logic buffer_reset_o, offset_binary_o, byte_mode_o, sinc_comp_en_o, gain_offset_en_o, upsample_1x_o;
  logic [3:0] lane_power_off_o;
  dfc_byte_t mdl [0:255];
  dfc_addr_t alst [9] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h39, 8'h3b, 8'h3a};
  int fail_count = 0, n_tests = 0, w, k, r;
  dfc_byte_t d;
  dfc_config_regs i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .meas_depth_int_i(meas_depth_int_i),
    .meas_depth_frac_i(meas_depth_frac_i), .level_valid_i(level_valid_i), .buffer_reset_o(buffer_reset_o),
    .depth_req_int_o(depth_req_int_o), .depth_req_frac_o(depth_req_frac_o), .offset_binary_o(offset_binary_o),
    .byte_mode_o(byte_mode_o), .sinc_comp_en_o(sinc_comp_en_o), .gain_offset_en_o(gain_offset_en_o),
    .upsample_1x_o(upsample_1x_o), .lane_power_off_o(lane_power_off_o), .dc_offset_high_i(dc_offset_high_i),
    .sample_i(sample_i), .sample_o(sample_o));
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  // writable bits per register; anything else stores nothing
  function automatic dfc_byte_t msk(input dfc_addr_t a);
    case (a)
      8'h23: msk = 8'h77;
      8'h25: msk = 8'h01;
      8'h26: msk = 8'h81;
      8'h27: msk = 8'ha0;
      8'h28: msk = 8'h80;
      8'h39: msk = 8'h0f;
      8'h3b: msk = 8'hff;
      default: msk = 8'h00;
    endcase
  endfunction : msk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  // one-cycle strobes; the model follows each write through the mask
  task automatic wr(input dfc_addr_t a, input dfc_byte_t v);
    @(posedge clk_i) #1;
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(posedge clk_i) #1;
    reg_wr_i = 1'b0;
    mdl[a] = v & msk(a);
  endtask : wr
  task automatic rd(input dfc_addr_t a, input dfc_byte_t e);
    @(posedge clk_i) #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_i) #1;
    reg_rd_i = 1'b0;
    chk($sformatf("reg %h", a), 16'(e), 16'(reg_rdata_o));
  endtask : rd
  task automatic chk_out();
    chk("depth_int", 16'(mdl[8'h23][6:4]), 16'(depth_req_int_o));
    chk("depth_frac", 16'(mdl[8'h23][2:0]), 16'(depth_req_frac_o));
    chk("fmt", 16'({mdl[8'h26][7], mdl[8'h26][0]}), 16'({offset_binary_o, byte_mode_o}));
    chk("stage", 16'({mdl[8'h27][7], mdl[8'h27][5]}), 16'({sinc_comp_en_o, gain_offset_en_o}));
    chk("ups", 16'(mdl[8'h28][7]), 16'(upsample_1x_o));
    chk("lanes", 16'(mdl[8'h39][3:0]), 16'(lane_power_off_o));
  endtask : chk_out
  task automatic wait_pulse(input logic lvl);
    w = 0;
    while (buffer_reset_o !== lvl) begin
      @(posedge clk_i) #1;
      w++;
      if (w > 20) begin
        fail_count++;
        test_done();
      end
    end
  endtask : wait_pulse
  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, random writes, buffer reset, sample path
  initial begin
    void'($urandom(28));
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h23] = 8'h40;
    repeat (16) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (alst[i]) rd(alst[i], mdl[alst[i]]);
    chk_out();
    $display("test reset values done");
    for (r = 0; r < 4; r++) begin
      foreach (alst[i]) begin
        d = 8'($urandom);
        if (alst[i] == 8'h23) d[2:0] = {2'b00, d[0] & ~mdl[8'h28][7]};
        // no switch to 1x while a fractional depth is still requested
        if (alst[i] == 8'h28 && mdl[8'h23][2:0] != 3'h0) d[7] = 1'b0;
        if (alst[i] != 8'h25) wr(alst[i], d);
      end
      chk_out();
      foreach (alst[i]) rd(alst[i], mdl[alst[i]]);
    end
    $display("test register access done");
    wr(8'h23, 8'h40);
    meas_depth_int_i = 3'h4;
    meas_depth_frac_i = 3'h1;
    wr(8'h25, 8'h01);
    wait_pulse(1'b1);
    wait_pulse(1'b0);
    chk("pulse", 16'h0004, 16'(w));
    rd(8'h25, 8'h01);
    rd(8'h24, 8'h00);
    level_valid_i = 1'b1;
    repeat (2) @(posedge clk_i) #1;
    rd(8'h25, 8'h03);
    rd(8'h24, 8'h41);
    wr(8'h25, 8'h00);
    @(posedge clk_i) #1;
    rd(8'h25, 8'h00);
    // readback must hold its last settled level while the buffer is unsettled
    level_valid_i = 1'b0;
    meas_depth_int_i = 3'h2;
    meas_depth_frac_i = 3'h0;
    repeat (2) @(posedge clk_i) #1;
    rd(8'h24, 8'h41);
    $display("test buffer reset done");
    wr(8'h3b, 8'($urandom));
    dc_offset_high_i = 8'($urandom);
    for (k = 0; k < 2; k++) begin
      wr(8'h27, k ? 8'h20 : 8'h00);
      for (r = 0; r < 8; r++) begin
        sample_i = 16'($urandom);
        expv = sample_i + (k ? {dc_offset_high_i, mdl[8'h3b]} : 16'h0000);
        @(posedge clk_i) #1;
        chk("sample", expv, sample_o);
      end
    end
    $display("test sample path done");
    test_done();
  end
endmodule : tb_dfc_config_regs
